/* bench/datb_checker.sv */
/*
 port checker for the trim bank: frame timing, loads and drops.
 assumes it is bound onto datb_trim_bank and sees only its ports.
*/
`timescale 1ns/1ns
`default_nettype none
module datb_checker (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic serial_clk,
   input wire logic serial_data,
   input wire logic serial_chip_select_n,
   input wire logic extended_mode,
   input wire datb_pkg::datb_trim_s trim,
   input wire logic frame_done
);
   // ========================================
   // frame capture
   logic sd, emd;
   logic [31:0] sh;
   logic [4:0] cnt;
   logic [3:0] age;
   wire logic rise = serial_clk & ~sd & ~serial_chip_select_n;
   wire logic [3:0] ad = sh[19:16];
   wire logic go = frame_done & emd & extended_mode & sh[31:20] == 12'h001;
   wire logic ok = ad == 4'h3 || ad > 4'h9 && ad != 4'hc;
   wire logic idle = trim == 43'h40200000000;
   // raw pins suffice here, no metastability in simulation
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         {sd, emd, cnt, age, sh} <= {11'h00f, 32'h0};
      end else begin
         {sd, emd} <= {serial_clk, extended_mode};
         age <= rise ? 4'h0 : age + {3'h0, age != 4'hf};
         cnt <= serial_chip_select_n ? 5'h0 : cnt + {4'h0, rise};
         if (rise)
            sh <= {sh[30:0], serial_data};
      end
   end
   // ========================================
   // assertions
   default clocking @(posedge core_clk);
   endclocking
   default disable iff (sys_rst);
   a_reset_idle: assert property ($fell(sys_rst) |-> idle)
      else $error("trim not idle after reset");
   a_done_count: assert property (frame_done |->
      cnt == 5'h0 && age inside {[1:7]}) else $error("bad frame end");
   // trim is registered once more than frame_done, so look a cycle on
   a_gain_load: assert property (go && ad[2:0] == 3'h3 |=>
      (ad[3] ? trim.gain_q : trim.gain_i) == sh[15:7])
      else $error("gain not loaded");
   a_offset_load: assert property (go && ad == 4'ha |=>
      {trim.offset_q_mag, trim.offset_q_neg} == sh[15:7])
      else $error("offset not loaded");
   a_mode_load: assert property (go && ad == 4'hd |=>
      {trim.interleave_enable, trim.auto_phase_control} == sh[15:14])
      else $error("mode not loaded");
   a_auto_hides: assert property (trim.auto_phase_control |->
      trim.coarse_skew_magnitude == 3'h0 && trim.fine_skew_magnitude == 9'h0)
      else $error("manual skew leaks");
   a_drop_frame: assert property (frame_done && !(go && ok) |=>
      $stable(trim)) else $error("bad frame changed trim");
   a_normal_idle: assert property (
      !extended_mode && !emd |-> idle) else $error("trim active in normal mode");
   c_gain: cover property (go && ad == 4'h3);
   c_auto: cover property (trim.auto_phase_control);
   c_drop: cover property (frame_done && !go);
endmodule
`default_nettype wire

/* bench/datb_host.sv */
/*
 host model shifting 32-bit frames into the serial pins.
 assumes core_clk at 100 MHz; serial clock period is 8 core cycles.
*/
`timescale 1ns/1ns
`default_nettype none
module datb_host (
   input wire logic core_clk,
   output logic serial_clk,
   output logic serial_data,
   output logic serial_chip_select_n
);
   // idle: clock still low, select high
   initial begin
      {serial_clk, serial_data, serial_chip_select_n} = 3'b001;
   end
   task automatic wt(input int n);
      repeat (n) @(negedge core_clk);
   endtask
   // n bits msb first; k keeps select low for the next frame
   task automatic send(input logic [31:0] f, input int n, input bit k);
      serial_chip_select_n = 1'b0;
      for (int i = 31; i > 31 - n; i--) begin
         serial_data = f[i];
         wt(4);
         serial_clk = 1'b1;
         wt(4);
         serial_clk = 1'b0; // data held four cycles past the edge
      end
      wt(8);
      if (!k) begin
         serial_chip_select_n = 1'b1;
         serial_data = ~serial_data; // no stale bit once released
         wt(8);
      end
   endtask
endmodule
`default_nettype wire

/* bench/tb.sv */
/*
 bench top: trim bank, host model and bound checker.
 assumes the package and design files are compiled first.
*/
`timescale 1ns/1ns
`default_nettype none
module tb;
   localparam logic [42:0] IDLE = 43'h40200000000;
   logic core_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic extended_mode = 1'b1;
   logic ck, dq, sel_n, frame_done;
   datb_pkg::datb_trim_s trim, e, h;
   int n_errors = 0;
   int n_checks = 0;
   int n_done = 0;
   int cyc = 0;
   always #5 core_clk = ~core_clk;
   datb_trim_bank u_dut (.core_clk(core_clk), .sys_rst(sys_rst),
      .serial_clk(ck), .serial_data(dq), .serial_chip_select_n(sel_n),
      .extended_mode(extended_mode), .trim(trim), .frame_done(frame_done));
   datb_host u_host (.core_clk(core_clk), .serial_clk(ck),
      .serial_data(dq), .serial_chip_select_n(sel_n));
   // ========================================
   // helpers
   task automatic chk(input string what, input logic [42:0] s,
      input logic [42:0] x);
      n_checks++;
      if (s !== x) begin
         n_errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, x, s);
      end
   endtask
   task automatic tally_and_finish;
      if (n_errors == 0 && n_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   // unused low bits always written as ones
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      u_host.send({12'h001, a, d}, 32, 1'b0);
   endtask
   // completed frames; the one-cycle pulse stands at the falling edge
   always @(negedge core_clk) begin
      if (frame_done === 1'b1)
         n_done++;
   end
   // hang guard, tests need about 4000 cycles
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 8000) begin
         n_errors++;
         tally_and_finish();
      end
   end
   // ========================================
   // tests
   initial begin
      repeat (5) @(posedge core_clk);
      @(negedge core_clk);
      sys_rst = 1'b0;
      @(negedge core_clk);
      e = IDLE;
      chk("trim", trim, e);
      wr(4'h3, 16'h607f);
      e.gain_i = 9'h0c0;
      chk("trim", trim, e);
      wr(4'hb, 16'he07f);
      e.gain_q = 9'h1c0;
      chk("trim", trim, e);
      wr(4'ha, 16'h127f);
      e.offset_q_mag = 8'h12;
      chk("trim", trim, e);
      wr(4'ha, 16'habff);
      e.offset_q_mag = 8'hab;
      e.offset_q_neg = 1'b1;
      chk("trim", trim, e);
      // two frames under one select
      u_host.send({12'h001, 4'he, 16'hefff}, 32, 1'b1);
      u_host.send({12'h001, 4'hf, 16'h80ff}, 32, 1'b0);
      e.interleave_input_choice = 1'b1;
      e.skew_direction = 1'b1;
      e.coarse_skew_magnitude = 3'h5;
      e.fine_skew_magnitude = 9'h101;
      chk("trim", trim, e);
      // automatic phase hides manual skew, clearing it restores
      wr(4'hd, 16'hffff);
      h = e;
      h.interleave_enable = 1'b1;
      h.auto_phase_control = 1'b1;
      h.coarse_skew_magnitude = 3'h0;
      h.fine_skew_magnitude = 9'h0;
      chk("trim", trim, h);
      wr(4'hd, 16'h3fff);
      chk("trim", trim, e);
      // reserved place, wrong header, aborted frame
      wr(4'h5, 16'hffff);
      chk("trim", trim, e);
      u_host.send({12'h003, 4'h3, 16'h007f}, 32, 1'b0);
      chk("trim", trim, e);
      u_host.send({12'h001, 4'h3, 16'h007f}, 16, 1'b0);
      chk("trim", trim, e);
      wr(4'hd, 16'hbfff);
      e.interleave_enable = 1'b1;
      chk("trim", trim, e);
      // normal mode hides every setting
      extended_mode = 1'b0;
      repeat (3) @(negedge core_clk);
      chk("trim", trim, IDLE);
      extended_mode = 1'b1;
      repeat (3) @(negedge core_clk);
      chk("trim", trim, e);
      // interleave cleared first, then the unheld configuration place
      wr(4'hd, 16'h3fff);
      e.interleave_enable = 1'b0;
      chk("trim", trim, e);
      wr(4'h1, 16'hb2ff);
      chk("trim", trim, e);
      // mid-run reset brings back every power-on value
      sys_rst = 1'b1;
      repeat (3) @(negedge core_clk);
      sys_rst = 1'b0;
      @(negedge core_clk);
      chk("trim", trim, IDLE);
      chk("frame_done count", 43'(n_done), 43'h00d);
      tally_and_finish();
   end
endmodule
bind datb_trim_bank datb_checker u_chk (.core_clk(core_clk),
   .sys_rst(sys_rst), .serial_clk(serial_clk), .serial_data(serial_data),
   .serial_chip_select_n(serial_chip_select_n),
   .extended_mode(extended_mode), .trim(trim), .frame_done(frame_done));
`default_nettype wire

/* logic/datb_pkg.sv */
/*
 package for the dual converter trim register bank: frame layout,
 register addresses, reset values and field positions.
 assumes nothing of its surroundings.
*/
`default_nettype none
package datb_pkg;
   // ========================================
   // serial frame
   localparam int unsigned FRAME_BITS = 32;
   localparam logic [5:0] FRAME_LAST = 6'h1f;
   localparam logic [11:0] FRAME_HEADER = 12'h001;
   // ========================================
   // register addresses
   localparam logic [3:0] ADDR_GAIN_I = 4'h3;
   localparam logic [3:0] ADDR_OFFSET_Q = 4'ha;
   localparam logic [3:0] ADDR_GAIN_Q = 4'hb;
   localparam logic [3:0] ADDR_INTERLEAVE = 4'hd;
   localparam logic [3:0] ADDR_COARSE = 4'he;
   localparam logic [3:0] ADDR_FINE = 4'hf;
   // ========================================
   // reset values
   localparam logic [15:0] RST_GAIN = 16'h807f;
   localparam logic [15:0] RST_OFFSET = 16'h007f;
   localparam logic [15:0] RST_INTERLEAVE = 16'h3fff;
   localparam logic [15:0] RST_COARSE = 16'h07ff;
   localparam logic [15:0] RST_FINE = 16'h007f;
   // ========================================
   // field positions
   localparam int unsigned GAIN_MSB = 15;
   localparam int unsigned GAIN_LSB = 7;
   localparam int unsigned OFFSET_MSB = 15;
   localparam int unsigned OFFSET_LSB = 8;
   localparam int unsigned OFFSET_SIGN = 7;
   localparam int unsigned IL_ENABLE_BIT = 15;
   localparam int unsigned IL_AUTO_BIT = 14;
   localparam int unsigned CS_INPUT_BIT = 15;
   localparam int unsigned CS_DIR_BIT = 14;
   localparam int unsigned CS_MAG_MSB = 13;
   localparam int unsigned CS_MAG_LSB = 11;
   localparam int unsigned FINE_MSB = 15;
   localparam int unsigned FINE_LSB = 7;

   // trim settings handed to the analog side
   typedef struct packed {
      logic [8:0] gain_i;
      logic [8:0] gain_q;
      logic [7:0] offset_q_mag;
      logic offset_q_neg;
      logic interleave_enable;
      logic auto_phase_control;
      logic interleave_input_choice;
      logic skew_direction;
      logic [2:0] coarse_skew_magnitude;
      logic [8:0] fine_skew_magnitude;
   } datb_trim_s;
endpackage
`default_nettype wire

/* logic/datb_trim_bank.sv */
/*
 write-only trim register bank of a dual 8-bit converter, loaded by
 32-bit serial frames. the serial clock, data and chip select come from
 pins and are synchronised to core_clk; the serial clock must be slower
 than a quarter of core_clk. extended_mode comes from core_clk logic.
*/
`timescale 1ns/1ns
`default_nettype none
module datb_trim_bank (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic serial_clk,
   input wire logic serial_data,
   input wire logic serial_chip_select_n,
   input wire logic extended_mode,
   output datb_pkg::datb_trim_s trim,
   output logic frame_done
);

   // ========================================
   // pin synchronisers
   logic [1:0] sclk_sync;
   logic [1:0] sdat_sync;
   logic [1:0] scs_sync;
   logic sclk_prev;
   logic sdat_prev;

   // second stage is read for clock and select, a third for data; extra clock stage finds the rising edge
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         sclk_sync <= 2'h0;
         sdat_sync <= 2'h0;
         scs_sync <= 2'h3;
         sclk_prev <= 1'b0;
         sdat_prev <= 1'b0;
      end else begin
         sclk_sync <= {sclk_sync[0], serial_clk};
         sdat_sync <= {sdat_sync[0], serial_data};
         scs_sync <= {scs_sync[0], serial_chip_select_n};
         sclk_prev <= sclk_sync[1];
         sdat_prev <= sdat_sync[1];
      end
   end

   logic sclk_rise;
   logic sel;
   assign sclk_rise = sclk_sync[1] & ~sclk_prev;
   assign sel = ~scs_sync[1];

   // ========================================
   // frame shifter
   logic [30:0] shift;
   logic [5:0] bit_count;
   logic [31:0] frame;
   logic frame_end;
   logic [30:0] next_shift;
   logic [5:0] next_bit_count;
   logic next_frame_done;

   // data sampled one core cycle late, matched to the delayed clock
   assign frame = {shift, sdat_prev};
   assign frame_end = sel && sclk_rise && (bit_count == datb_pkg::FRAME_LAST);

   // count clears so the 33rd edge opens a new frame
   always_comb begin
      next_shift = shift;
      next_bit_count = bit_count;
      next_frame_done = 1'b0;
      if (!sel) begin
         next_bit_count = 6'h00; // deselect abandons a part frame
      end else if (sclk_rise) begin
         next_shift = frame[30:0]; // msb first
         if (frame_end) begin
            next_bit_count = 6'h00;
            next_frame_done = 1'b1;
         end else begin
            next_bit_count = bit_count + 6'h01;
         end
      end
   end

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         shift <= 31'h0;
         bit_count <= 6'h00;
         frame_done <= 1'b0;
      end else begin
         shift <= next_shift;
         bit_count <= next_bit_count;
         frame_done <= next_frame_done;
      end
   end

   // ========================================
   // register file
   logic [15:0] gain_i;
   logic [15:0] offset_q;
   logic [15:0] gain_q;
   logic [15:0] interleave_control;
   logic [15:0] coarse_skew_control;
   logic [15:0] fine_skew_control;
   logic load_gain_i;
   logic load_offset_q;
   logic load_gain_q;
   logic load_interleave;
   logic load_coarse;
   logic load_fine;
   logic wr_ok;
   logic [3:0] wr_addr;
   logic [15:0] wr_data;
   logic hdr_ok;

   assign wr_addr = frame[19:16];
   assign wr_data = frame[15:0];
   assign hdr_ok = frame[31:20] == datb_pkg::FRAME_HEADER;

   // write only after the 32nd bit; bad header or reserved address
   // raises no strobe and leaves every register alone
   assign wr_ok = frame_end && hdr_ok;

   // one load strobe per implemented address, none for the rest
   always_comb begin
      load_gain_i = 1'b0;
      load_offset_q = 1'b0;
      load_gain_q = 1'b0;
      load_interleave = 1'b0;
      load_coarse = 1'b0;
      load_fine = 1'b0;
      if (wr_ok) begin
         case (wr_addr)
            datb_pkg::ADDR_GAIN_I: load_gain_i = 1'b1;
            datb_pkg::ADDR_OFFSET_Q: load_offset_q = 1'b1;
            datb_pkg::ADDR_GAIN_Q: load_gain_q = 1'b1;
            datb_pkg::ADDR_INTERLEAVE: load_interleave = 1'b1;
            datb_pkg::ADDR_COARSE: load_coarse = 1'b1;
            datb_pkg::ADDR_FINE: load_fine = 1'b1;
            default: load_gain_i = 1'b0;
         endcase
      end
   end

   // power-on values
   // unused low bits are kept as written; nothing downstream reads them
   datb_trim_reg #(
      .RESET_VALUE(datb_pkg::RST_GAIN)
   ) u_gain_i (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .load(load_gain_i),
      .load_data(wr_data),
      .value(gain_i)
   );

   datb_trim_reg #(
      .RESET_VALUE(datb_pkg::RST_OFFSET)
   ) u_offset_q (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .load(load_offset_q),
      .load_data(wr_data),
      .value(offset_q)
   );

   datb_trim_reg #(
      .RESET_VALUE(datb_pkg::RST_GAIN)
   ) u_gain_q (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .load(load_gain_q),
      .load_data(wr_data),
      .value(gain_q)
   );

   datb_trim_reg #(
      .RESET_VALUE(datb_pkg::RST_INTERLEAVE)
   ) u_interleave (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .load(load_interleave),
      .load_data(wr_data),
      .value(interleave_control)
   );

   datb_trim_reg #(
      .RESET_VALUE(datb_pkg::RST_COARSE)
   ) u_coarse (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .load(load_coarse),
      .load_data(wr_data),
      .value(coarse_skew_control)
   );

   datb_trim_reg #(
      .RESET_VALUE(datb_pkg::RST_FINE)
   ) u_fine (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .load(load_fine),
      .load_data(wr_data),
      .value(fine_skew_control)
   );

   // ========================================
   // trim outputs
   datb_pkg::datb_trim_s next_trim;
   localparam logic [8:0] GAIN_IDLE =
      datb_pkg::RST_GAIN[datb_pkg::GAIN_MSB:datb_pkg::GAIN_LSB];

   // outside extended mode every field shows its reset meaning, so the
   // analog side sees no trim; gain goes straight out, no recalibration
   always_comb begin
      next_trim.gain_i = gain_i[datb_pkg::GAIN_MSB:datb_pkg::GAIN_LSB];
      next_trim.gain_q = gain_q[datb_pkg::GAIN_MSB:datb_pkg::GAIN_LSB];
      next_trim.offset_q_mag =
         offset_q[datb_pkg::OFFSET_MSB:datb_pkg::OFFSET_LSB];
      next_trim.offset_q_neg = offset_q[datb_pkg::OFFSET_SIGN];
      next_trim.interleave_enable =
         interleave_control[datb_pkg::IL_ENABLE_BIT];
      next_trim.auto_phase_control =
         interleave_control[datb_pkg::IL_AUTO_BIT];
      next_trim.interleave_input_choice =
         coarse_skew_control[datb_pkg::CS_INPUT_BIT];
      next_trim.skew_direction =
         coarse_skew_control[datb_pkg::CS_DIR_BIT];
      next_trim.coarse_skew_magnitude =
         coarse_skew_control[datb_pkg::CS_MAG_MSB:datb_pkg::CS_MAG_LSB];
      next_trim.fine_skew_magnitude =
         fine_skew_control[datb_pkg::FINE_MSB:datb_pkg::FINE_LSB];
      // automatic phase zeroes the manual skew
      if (next_trim.auto_phase_control) begin
         next_trim.coarse_skew_magnitude = 3'h0;
         next_trim.fine_skew_magnitude = 9'h000;
      end
      if (!extended_mode) begin
         next_trim.gain_i = GAIN_IDLE;
         next_trim.gain_q = GAIN_IDLE;
         next_trim.offset_q_mag = 8'h00;
         next_trim.offset_q_neg = 1'b0;
         next_trim.interleave_enable = 1'b0;
         next_trim.auto_phase_control = 1'b0;
         next_trim.interleave_input_choice = 1'b0;
         next_trim.skew_direction = 1'b0;
         next_trim.coarse_skew_magnitude = 3'h0;
         next_trim.fine_skew_magnitude = 9'h000;
      end
   end

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         trim <= '0;
         trim.gain_i <= GAIN_IDLE;
         trim.gain_q <= GAIN_IDLE;
      end else begin
         trim <= next_trim;
      end
   end

endmodule

// ========================================
// one write-only trim register
// a plain load register; the bank keeps one per implemented address
module datb_trim_reg #(
   parameter logic [15:0] RESET_VALUE = 16'h0000
) (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic load,
   input wire logic [15:0] load_data,
   output logic [15:0] value
);

   logic [15:0] next_value;

   // hold unless the decoder strobes this register
   always_comb begin
      next_value = value;
      if (load) begin
         next_value = load_data;
      end
   end

   // async branch loads a constant only, never live data
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         value <= RESET_VALUE;
      end else begin
         value <= next_value;
      end
   end

endmodule
`default_nettype wire
